// [hdl/stoi_interlock.sv]
// Dual-channel safe torque off interlock: gate enable, monitors, timing alarm.
// Assumes inputs synchronous to sys_clk and motor status from the drive core.
`timescale 1ns/1ns

// What this block and its far end do
// (RULE1) Open input A shuts off gate drive
// (RULE2) Closed A releases only with B released
// (RULE3) Open input B shuts off gate independently
// (RULE4) Closed B releases only with A released
// (RULE5) Monitor A closed while channel A off
// (RULE6) Monitor A open while channel A released
// (RULE7) Monitor B follows channel B shut-off state
// (RULE8) Series monitor shows shut-off unless both on
// (RULE9) Far end test pulses at most 1 ms
// (RULE10) Far end opens inputs after motor stops
// (RULE11) Open while running: dynamic brake, alarm
// (RULE12) Far end opens both inputs together
// (RULE13) Filter off pulses up to test width
module stoi_interlock
  import stoi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire stoi_inputs_s safety_in,
  input wire logic motor_running,
  input wire logic alarm_clear,
  output logic gate_enable,
  output logic dynamic_brake,
  output logic torque_off_timing_alarm,
  output stoi_monitors_s monitors
);

  // ****************************************************************
  // Channel filters
  // ****************************************************************
  logic rel_a;
  logic rel_b;
  logic both_release;
  stoi_state_e state;
  stoi_state_e next_state;

  stoi_filter u_filt_a
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .raw_closed(safety_in.torque_off_input_a),
    .chan_release(rel_a)
  );

  stoi_filter u_filt_b
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .raw_closed(safety_in.torque_off_input_b),
    .chan_release(rel_b)
  );

  // Both channels must agree before torque may flow
  assign both_release = rel_a & rel_b; // see (RULE2) see (RULE4)

  // ****************************************************************
  // Interlock state
  // ****************************************************************
  // Alarm is sticky until cleared with the motor stopped; even so, a
  // cleared alarm cannot restart torque while a channel is still off
  always_comb
  begin
    next_state = state;
    case (state)
      STOI_SHUTOFF:
      begin
        if (both_release)
          next_state = STOI_RELEASE;
      end
      STOI_RELEASE:
      begin
        if (!both_release && motor_running)
          next_state = STOI_ALARM; // see (RULE11)
        else if (!both_release)
          next_state = STOI_SHUTOFF; // see (RULE1) see (RULE3)
      end
      STOI_ALARM:
      begin
        if (alarm_clear && !motor_running)
          next_state = STOI_SHUTOFF;
      end
      default:
        next_state = STOI_SHUTOFF;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      state <= STOI_SHUTOFF;
    else
      state <= next_state;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Gate enable also drops directly on a channel drop, on the same edge as state
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      gate_enable <= 1'b0;
    else
      gate_enable <= both_release && (state != STOI_ALARM); // see (RULE1) see (RULE3)
  end

  // Dynamic brake and alarm while stopping a moving motor
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      dynamic_brake <= 1'b0;
      torque_off_timing_alarm <= ALARM_RESET;
    end
    else
    begin
      dynamic_brake <= (next_state == STOI_ALARM); // see (RULE11)
      torque_off_timing_alarm <= (next_state == STOI_ALARM); // see (RULE11)
    end
  end

  // Monitors are closed (high) in shut-off; series path is closed if either is
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      monitors <= 3'h7;
    else
    begin
      monitors.torque_off_monitor_a <= !rel_a; // see (RULE5) see (RULE6)
      monitors.torque_off_monitor_b <= !rel_b; // see (RULE7)
      monitors.series_monitor <= !(rel_a && rel_b); // see (RULE8)
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Run of open samples on each input, counted apart from the filters so the
  // checks below catch a filter that is too short or one that never trips
  logic [FILT_W-1:0] open_run_a;
  logic [FILT_W-1:0] open_run_b;

  // Input A open run, saturating at the filter limit
  always_ff @(posedge sys_clk)
  begin
    if (reset || safety_in.torque_off_input_a)
      open_run_a <= '0;
    else if (open_run_a != FILTER_LIMIT)
      open_run_a <= open_run_a + 1'b1;
  end

  // Input B open run, saturating at the filter limit
  always_ff @(posedge sys_clk)
  begin
    if (reset || safety_in.torque_off_input_b)
      open_run_b <= '0;
    else if (open_run_b != FILTER_LIMIT)
      open_run_b <= open_run_b + 1'b1;
  end

  a_gate_needs_both: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE2)
    gate_enable |-> $past(rel_a) && $past(rel_b))
    else $error("gate enabled without both channels released");

  a_chan_a_cuts: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE1)
    $fell(rel_a) |=> !gate_enable)
    else $error("channel a drop did not cut gate");

  a_chan_b_cuts: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE3)
    $fell(rel_b) |=> !gate_enable)
    else $error("channel b drop did not cut gate");

  a_release_gate: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE4)
    (rel_a && rel_b && state == STOI_RELEASE) |=> gate_enable)
    else $error("gate not enabled in release");

  a_monitor_a_map: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE5)
    ##1 monitors.torque_off_monitor_a == !$past(rel_a))
    else $error("monitor a mismatch");

  a_monitor_a_open: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE6)
    $rose(rel_a) |=> !monitors.torque_off_monitor_a)
    else $error("monitor a not opened on release");

  a_monitor_b_map: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE7)
    $fell(rel_b) |=> monitors.torque_off_monitor_b)
    else $error("monitor b not closed on shut-off");

  a_monitor_b_open: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE7)
    $rose(rel_b) |=> !monitors.torque_off_monitor_b)
    else $error("monitor b not opened on release");

  a_series_path: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE8)
    monitors.series_monitor ==
      (monitors.torque_off_monitor_a || monitors.torque_off_monitor_b))
    else $error("series monitor inconsistent");

  a_series_shutoff: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE8)
    (!rel_a || !rel_b) |=> monitors.series_monitor)
    else $error("series monitor open with a channel off");

  a_series_release: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE8)
    (rel_a && rel_b) |=> !monitors.series_monitor)
    else $error("series monitor closed with both channels on");

  a_alarm_on_run: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE11)
    (state == STOI_RELEASE && !both_release && motor_running)
      |=> torque_off_timing_alarm && dynamic_brake && !gate_enable)
    else $error("running drop did not raise alarm");

  a_alarm_sticky: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE11)
    (torque_off_timing_alarm && motor_running) |=> torque_off_timing_alarm)
    else $error("alarm dropped while motor still running");

  a_alarm_no_gate: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE11)
    torque_off_timing_alarm |-> !gate_enable)
    else $error("gate enabled during alarm");

  a_pulse_absorbed: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE13)
    (rel_a && $fell(safety_in.torque_off_input_a)) |=> rel_a [*8])
    else $error("short off pulse changed channel a");

  a_pulse_absorbed_b: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE13)
    (rel_b && $fell(safety_in.torque_off_input_b)) |=> rel_b [*8])
    else $error("short off pulse changed channel b");

  // A channel may only drop once its input stayed open past a full test pulse
  a_drop_len_a: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE13)
    $fell(rel_a) |-> (open_run_a == FILTER_LIMIT))
    else $error("channel a dropped on a short open");

  a_drop_len_b: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE13)
    $fell(rel_b) |-> (open_run_b == FILTER_LIMIT))
    else $error("channel b dropped on a short open");

  // A lasting open must reach shut-off, whatever the other channel does
  a_open_cuts_a: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE1)
    (open_run_a == FILTER_LIMIT) |-> !rel_a)
    else $error("channel a still released after lasting open");

  a_open_cuts_b: assert property (@(posedge sys_clk) disable iff (reset) // see (RULE3)
    (open_run_b == FILTER_LIMIT) |-> !rel_b)
    else $error("channel b still released after lasting open");

endmodule

// [hdl/stoi_pkg.sv]
// Shared constants and carrier types for the torque off interlock.
// Assumes a single 10 MHz system clock and synchronous active-high reset.
package stoi_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  // Longest off test pulse the far end may apply
  localparam int TEST_PULSE_US = 1000;
  // Filter holds one cycle beyond the pulse so a full 1 ms pulse is absorbed
  localparam int FILTER_CYCLES = (TEST_PULSE_US * 1000) / CLK_PERIOD_NS + 1;
  localparam int FILT_W = 14;
  localparam logic [FILT_W-1:0] FILTER_LIMIT = FILTER_CYCLES[FILT_W-1:0];

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic CHAN_RESET = 1'b0;   // Channel starts in shut-off
  localparam logic ALARM_RESET = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    STOI_SHUTOFF = 3'h1,
    STOI_RELEASE = 3'h2,
    STOI_ALARM = 3'h4
  } stoi_state_e;

  typedef struct packed {
    logic torque_off_input_a;   // High = closed to safety_input_common
    logic torque_off_input_b;
  } stoi_inputs_s;

  typedef struct packed {
    logic torque_off_monitor_a; // High = closed to monitor_output_common
    logic torque_off_monitor_b;
    logic series_monitor;       // High = overall shut-off
  } stoi_monitors_s;

endpackage

// [hdl/stoi_filter.sv]
// One channel input filter for the torque off interlock.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/1ns
module stoi_filter
  import stoi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic raw_closed,
  output logic chan_release
);

  logic [FILT_W-1:0] open_count;

  // Count consecutive open cycles; any closed cycle restarts the count
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      open_count <= '0;
    else if (raw_closed)
      open_count <= '0;
    else if (open_count != FILTER_LIMIT)
      open_count <= open_count + 1'b1; // see (RULE13)
  end

  // Release needs a closed input; shut-off only once the open outlasts a test pulse
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      chan_release <= CHAN_RESET;
    else if (raw_closed)
      chan_release <= 1'b1;
    else if (open_count == FILTER_LIMIT - 1'b1)
      chan_release <= 1'b0; // see (RULE13)
  end

endmodule

// [sim/stoi_relay.sv]
// Far-end safety relay model driving the two torque off contacts.
// Assumes the bench calls its tasks; changes land just after sys_clk rises.
`timescale 1ns/1ns
module stoi_relay
  import stoi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic motor_running,
  output stoi_inputs_s safety_out
);
  // ****************************************************************
  // Contact drive
  // ****************************************************************
  // Contacts stay open until the bench asks for release
  initial safety_out = 2'h0;

  // Set both contacts in one edge; opening waits for standstill unless forced
  // Late is set when the motor never stopped within the wait bound
  task automatic drive(input logic a, input logic b, input logic force_open,
    output logic late);
    int n = 0;
    while (motor_running && !force_open && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    late = motor_running && !force_open;
    @(posedge sys_clk);
    safety_out <= {a, b};
  endtask

  // Off test pulse, clipped so it never outlasts the allowed width
  task automatic pulse(input logic [1:0] mask, input int len);
    if (len > FILTER_CYCLES - 1)
      len = FILTER_CYCLES - 1;
    @(posedge sys_clk);
    safety_out <= safety_out & ~mask;
    repeat (len) @(posedge sys_clk);
    safety_out <= safety_out | mask;
  endtask
endmodule

// [sim/test_safe_torque_off_interlock.sv]
// Self-checking bench for the torque off interlock with a relay model.
// Assumes the 10001-cycle input filter and two-cycle release path.
`timescale 1ns/1ns
module test_safe_torque_off_interlock
  import stoi_pkg::*;
;
  // ****************************************************************
  // Harness
  // ****************************************************************
  logic sys_clk;
  logic reset;
  logic motor_running;
  logic alarm_clear;
  logic gate_enable;
  logic dynamic_brake;
  logic torque_off_timing_alarm;
  stoi_inputs_s safety_in;
  stoi_monitors_s monitors;
  int failures = 0;
  int tests_run = 0;
  logic relay_late;

  stoi_interlock i_dut (
    .sys_clk(sys_clk), .reset(reset), .safety_in(safety_in),
    .motor_running(motor_running), .alarm_clear(alarm_clear),
    .gate_enable(gate_enable), .dynamic_brake(dynamic_brake),
    .torque_off_timing_alarm(torque_off_timing_alarm), .monitors(monitors)
  );

  stoi_relay i_relay (
    .sys_clk(sys_clk), .motor_running(motor_running), .safety_out(safety_in)
  );

  // Free-running 10 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Step past edges so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Packed result: gate, brake, alarm, monitor a, monitor b, series
  task automatic chk(input string what, input logic [5:0] exp);
    logic [5:0] seen;
    seen = {gate_enable, dynamic_brake, torque_off_timing_alarm, monitors};
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A relay wait that used up its bound counts as a mismatch
  task automatic chk_wait(input logic late);
    tests_run++;
    if (late !== 1'b0)
    begin
      failures++;
      $display("wrong value relay wait expected 0 seen %b", late);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Release takes one cycle in the filter and one in the output registers
  task automatic t_release();
    i_relay.drive(1'b1, 1'b1, 1'b0, relay_late);
    chk_wait(relay_late);
    tick(1);
    chk("release wait", 6'h07);
    tick(1);
    chk("release", 6'h20);
  endtask

  // Full-width pulses must be swallowed; a filter one cycle short would
  // show a dropped gate on the first edge after the contact closes again
  task automatic t_pulse(input logic [1:0] mask);
    i_relay.pulse(mask, 20000);
    tick(1);
    chk("pulse", 6'h20);
  endtask

  // One channel opened with the motor at rest, then closed again
  task automatic t_open_one(input logic a, input logic b, input logic [5:0] exp);
    i_relay.drive(a, b, 1'b0, relay_late);
    chk_wait(relay_late);
    tick(10001);
    chk("filter hold", 6'h20);
    tick(1);
    chk("one open", exp);
    i_relay.drive(1'b1, 1'b1, 1'b0, relay_late);
    chk_wait(relay_late);
    tick(3);
    chk("re-release", 6'h20);
  endtask

  // Both opened while running: brake and alarm, clear refused until stopped
  task automatic t_alarm();
    @(posedge sys_clk);
    motor_running <= 1'b1;
    i_relay.drive(1'b0, 1'b0, 1'b1, relay_late);
    chk_wait(relay_late);
    tick(10001);
    chk("alarm pending", 6'h20);
    tick(1);
    chk("alarm", 6'h1F);
    @(posedge sys_clk);
    alarm_clear <= 1'b1;
    tick(3);
    chk("clear refused", 6'h1F);
    @(posedge sys_clk);
    motor_running <= 1'b0;
    tick(3);
    chk("cleared", 6'h07);
    @(posedge sys_clk);
    alarm_clear <= 1'b0;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    reset = 1'b1;
    motor_running = 1'b0;
    alarm_clear = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    chk("reset", 6'h07);
    t_release();
    t_pulse(2'h2);
    t_pulse(2'h1);
    t_open_one(1'b0, 1'b1, 6'h05);
    t_open_one(1'b1, 1'b0, 6'h03);
    t_alarm();
    end_sim();
  end
endmodule
